// [design/sfe_cfg.svh]
// register map, bit positions and reset values of the socket force event block
`ifndef SFE_CFG_SVH
`define SFE_CFG_SVH

// register byte offsets
`define SFE_OFF_EVENT 8'h00
`define SFE_OFF_MASK 8'h04
`define SFE_OFF_STATE 8'h08
`define SFE_OFF_FORCE 8'h0c
`define SFE_OFF_CTRL 8'h10

// event register / mask register layout
`define SFE_EV_STS 0
`define SFE_EV_CD1 1
`define SFE_EV_CD2 2
`define SFE_EV_PWR 3
`define SFE_EV_W 4

// present state register layout
`define SFE_ST_Y_SOCK 31
`define SFE_ST_X_SOCK 30
`define SFE_ST_3V3_SOCK 29
`define SFE_ST_5V_SOCK 28
`define SFE_ST_ZV 27
`define SFE_ST_VOLT_HI 13
`define SFE_ST_VOLT_LO 10
`define SFE_ST_BADVCC 9
`define SFE_ST_LOSS 8
`define SFE_ST_UNREC 7
`define SFE_ST_IRQ 6
`define SFE_ST_CB 5
`define SFE_ST_16 4
`define SFE_ST_PWR 3
`define SFE_ST_CD2 2
`define SFE_ST_CD1 1
`define SFE_ST_STS 0

// force register layout
`define SFE_FR_ZV 27
`define SFE_FR_RETEST 14
`define SFE_FR_VOLT_HI 13
`define SFE_FR_VOLT_LO 10
`define SFE_FR_BADVCC 9
`define SFE_FR_LOSS 8
`define SFE_FR_UNREC 7
`define SFE_FR_CB 5
`define SFE_FR_16 4
`define SFE_FR_PWR 3
`define SFE_FR_CD2 2
`define SFE_FR_CD1 1
`define SFE_FR_STS 0

// control/status register layout
`define SFE_CT_BUSY 0
`define SFE_CT_PWR_EN 1

// hardware socket voltage capabilities
`define SFE_HW_Y_SOCK 1'h0
`define SFE_HW_X_SOCK 1'h0
`define SFE_HW_3V3_SOCK 1'h1
`define SFE_HW_5V_SOCK 1'h1

// reset values
`define SFE_RST_WORD 32'h0000_0000
`define SFE_RST_EV 4'h0
`define SFE_RST_VOLT 4'h0
`define SFE_RST_PWR_EN 1'h1

`endif

// [design/sfe_pkg.sv]
// types shared by the socket force event block
package sfe_pkg;
  typedef enum logic [0:0] {
    SFE_IDLE = 1'b0,
    SFE_BUSY = 1'b1
  } sfe_state_t;
endpackage

// [design/sfe_force_event.sv]
// socket event, mask, present state and force registers behind a wishbone slave
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
`include "sfe_cfg.svh"

module sfe_force_event
  import sfe_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // live socket pins
  input wire logic detect_one_live_i,
  input wire logic detect_two_live_i,
  input wire logic status_change_live_i,
  input wire logic socket_powered_status_i,
  input wire logic ready_irq_live_i,
  // card interrogation engine
  input wire logic interrogate_done_i,
  input wire logic [3:0] card_volt_caps_i,
  input wire logic cardbus_detected_i,
  input wire logic sixteen_bit_detected_i,
  input wire logic unrecognized_card_i,
  input wire logic zoom_video_capable_i,
  output logic interrogate_start_o,
  // socket power control and interrupt
  output logic power_ctrl_enable_o,
  output logic irq_o
);

  // byte-lane mask from wishbone select
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // word address match
  function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] off);
    addr_is = (adr[7:2] == off[7:2]);
  endfunction

  sfe_state_t state;
  sfe_state_t next_state;

  logic req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic force_wr;
  logic event_wr;
  logic mask_wr;

  logic [`SFE_EV_W-1:0] event_flags;
  logic [`SFE_EV_W-1:0] event_mask;
  logic [`SFE_EV_W-1:0] hw_events;
  logic [`SFE_EV_W-1:0] force_sel;

  logic zoom_video_capable;
  logic [3:0] card_volt_caps;
  logic invalid_supply_request;
  logic possible_data_loss;
  logic unrecognized_card;
  logic cardbus_detected;
  logic sixteen_bit_detected;
  logic detect_one_live;
  logic detect_two_live;
  logic status_change_live;
  logic socket_powered_status;
  logic ready_irq_live;

  logic prev_cd1;
  logic prev_cd2;
  logic prev_sts;
  logic prev_pwr;

  logic retest;
  logic [3:0] volt_force_set;
  logic [31:0] state_word;
  logic [31:0] next_rdata;

  // an access is answered one cycle after it is presented; it acts at the ack edge
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & wb_ack_o;
  assign wmask = lane_mask(wb_sel_i);
  assign wval = wb_dat_i & wmask;
  assign force_wr = wr & addr_is(wb_adr_i, `SFE_OFF_FORCE);
  assign event_wr = wr & addr_is(wb_adr_i, `SFE_OFF_EVENT);
  assign mask_wr = wr & addr_is(wb_adr_i, `SFE_OFF_MASK);

  // bus ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // live pin sampling; detect pins freeze while an interrogation runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      detect_one_live <= 1'b1;
      detect_two_live <= 1'b1;
      status_change_live <= 1'b0;
      socket_powered_status <= 1'b0;
      ready_irq_live <= 1'b0;
    end else begin
      status_change_live <= status_change_live_i;
      socket_powered_status <= socket_powered_status_i;
      ready_irq_live <= ready_irq_live_i;
      if (state == SFE_IDLE) begin
        detect_one_live <= detect_one_live_i;
        detect_two_live <= detect_two_live_i;
      end
    end
  end

  // previous values for change detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_cd1 <= 1'b1;
      prev_cd2 <= 1'b1;
      prev_sts <= 1'b0;
      prev_pwr <= 1'b0;
    end else begin
      prev_cd1 <= detect_one_live;
      prev_cd2 <= detect_two_live;
      prev_sts <= status_change_live;
      prev_pwr <= socket_powered_status;
    end
  end

  always_comb begin
    hw_events = `SFE_RST_EV;
    hw_events[`SFE_EV_CD1] = detect_one_live ^ prev_cd1;
    hw_events[`SFE_EV_CD2] = detect_two_live ^ prev_cd2;
    hw_events[`SFE_EV_STS] = status_change_live & ~prev_sts;
    hw_events[`SFE_EV_PWR] = socket_powered_status ^ prev_pwr;
  end

  // force lanes that hit the event flags
  always_comb begin
    force_sel = `SFE_RST_EV;
    force_sel[`SFE_EV_STS] = wmask[`SFE_FR_STS];
    force_sel[`SFE_EV_CD1] = wmask[`SFE_FR_CD1];
    force_sel[`SFE_EV_CD2] = wmask[`SFE_FR_CD2];
    force_sel[`SFE_EV_PWR] = wmask[`SFE_FR_PWR];
  end

  // sticky event flags: hardware set wins over clear and over forced zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_flags <= `SFE_RST_EV;
    end else if (force_wr) begin
      event_flags <= ((event_flags & ~force_sel) |
                      (wval[`SFE_EV_W-1:0] & force_sel) | hw_events);
    end else if (event_wr) begin
      event_flags <= (event_flags & ~wval[`SFE_EV_W-1:0]) | hw_events;
    end else begin
      event_flags <= event_flags | hw_events;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_mask <= `SFE_RST_EV;
    end else if (mask_wr) begin
      event_mask <= wval[`SFE_EV_W-1:0] | (event_mask & ~wmask[`SFE_EV_W-1:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(event_flags & event_mask);
    end
  end

  // interrogation sequencing
  assign retest = force_wr & wval[`SFE_FR_RETEST];

  always_comb begin
    next_state = state;
    case (state)
      SFE_IDLE: begin
        if (retest) begin
          next_state = SFE_BUSY;
        end
      end
      SFE_BUSY: begin
        if (interrogate_done_i) begin
          next_state = SFE_IDLE;
        end
      end
      default: begin
        next_state = SFE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= SFE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrogate_start_o <= 1'b0;
    end else begin
      interrogate_start_o <= (state == SFE_IDLE) & retest;
    end
  end

  // socket power control enable
  assign volt_force_set = wval[`SFE_FR_VOLT_HI:`SFE_FR_VOLT_LO];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_ctrl_enable_o <= `SFE_RST_PWR_EN;
    end else if ((state == SFE_BUSY) & interrogate_done_i) begin
      power_ctrl_enable_o <= 1'b1;
    end else if (force_wr & (|volt_force_set)) begin
      power_ctrl_enable_o <= 1'b0;
    end
  end

  // present state flags: interrogation refreshes all but bad VCC and data loss; force writes override them unless an interrogation ends that cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zoom_video_capable <= 1'b0;
      card_volt_caps <= `SFE_RST_VOLT;
      invalid_supply_request <= 1'b0;
      possible_data_loss <= 1'b0;
      unrecognized_card <= 1'b0;
      cardbus_detected <= 1'b0;
      sixteen_bit_detected <= 1'b0;
    end else if ((state == SFE_BUSY) & interrogate_done_i) begin
      zoom_video_capable <= zoom_video_capable_i;
      card_volt_caps <= card_volt_caps_i;
      unrecognized_card <= unrecognized_card_i;
      cardbus_detected <= cardbus_detected_i;
      sixteen_bit_detected <= sixteen_bit_detected_i;
    end else if (force_wr) begin
      if (wmask[`SFE_FR_ZV]) begin
        zoom_video_capable <= wval[`SFE_FR_ZV];
      end
      if (wmask[`SFE_FR_VOLT_HI]) begin
        card_volt_caps[3:2] <= wval[`SFE_FR_VOLT_HI:`SFE_FR_VOLT_HI-1];
      end
      if (wmask[`SFE_FR_VOLT_LO]) begin
        card_volt_caps[1:0] <= wval[`SFE_FR_VOLT_LO+1:`SFE_FR_VOLT_LO];
      end
      if (wmask[`SFE_FR_BADVCC]) begin
        invalid_supply_request <= wval[`SFE_FR_BADVCC];
      end
      if (wmask[`SFE_FR_LOSS]) begin
        possible_data_loss <= wval[`SFE_FR_LOSS];
      end
      if (wmask[`SFE_FR_UNREC]) begin
        unrecognized_card <= wval[`SFE_FR_UNREC];
      end
      if (wmask[`SFE_FR_CB]) begin
        cardbus_detected <= wval[`SFE_FR_CB];
      end
      if (wmask[`SFE_FR_16]) begin
        sixteen_bit_detected <= wval[`SFE_FR_16];
      end
    end
  end

  // present state word
  always_comb begin
    state_word = `SFE_RST_WORD;
    state_word[`SFE_ST_Y_SOCK] = `SFE_HW_Y_SOCK;
    state_word[`SFE_ST_X_SOCK] = `SFE_HW_X_SOCK;
    state_word[`SFE_ST_3V3_SOCK] = `SFE_HW_3V3_SOCK;
    state_word[`SFE_ST_5V_SOCK] = `SFE_HW_5V_SOCK;
    state_word[`SFE_ST_ZV] = zoom_video_capable;
    state_word[`SFE_ST_VOLT_HI:`SFE_ST_VOLT_LO] = card_volt_caps;
    state_word[`SFE_ST_BADVCC] = invalid_supply_request;
    state_word[`SFE_ST_LOSS] = possible_data_loss;
    state_word[`SFE_ST_UNREC] = unrecognized_card;
    state_word[`SFE_ST_IRQ] = ready_irq_live;
    state_word[`SFE_ST_CB] = cardbus_detected;
    state_word[`SFE_ST_16] = sixteen_bit_detected;
    state_word[`SFE_ST_PWR] = socket_powered_status;
    state_word[`SFE_ST_CD2] = detect_two_live;
    state_word[`SFE_ST_CD1] = detect_one_live;
    state_word[`SFE_ST_STS] = status_change_live;
  end

  // read mux; force register and unmapped words read zero
  always_comb begin
    next_rdata = `SFE_RST_WORD;
    if (addr_is(wb_adr_i, `SFE_OFF_EVENT)) begin
      next_rdata[`SFE_EV_W-1:0] = event_flags;
    end else if (addr_is(wb_adr_i, `SFE_OFF_MASK)) begin
      next_rdata[`SFE_EV_W-1:0] = event_mask;
    end else if (addr_is(wb_adr_i, `SFE_OFF_STATE)) begin
      next_rdata = state_word;
    end else if (addr_is(wb_adr_i, `SFE_OFF_FORCE)) begin
      next_rdata = `SFE_RST_WORD;
    end else if (addr_is(wb_adr_i, `SFE_OFF_CTRL)) begin
      next_rdata[`SFE_CT_BUSY] = (state == SFE_BUSY);
      next_rdata[`SFE_CT_PWR_EN] = power_ctrl_enable_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `SFE_RST_WORD;
    end else if (req & ~wb_ack_o & ~wb_we_i) begin
      wb_dat_o <= next_rdata;
    end else begin
      wb_dat_o <= `SFE_RST_WORD;
    end
  end

endmodule // sfe_force_event

// [bench/sfe_force_event_checker.sv]
// port assertions for the socket force event block
`timescale 1ns/100ps
module sfe_force_event_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic interrogate_done_i,
  input wire logic interrogate_start_o,
  input wire logic power_ctrl_enable_o,
  input wire logic irq_o
);
  logic busy_q;
  // tracks an interrogation in flight
  always_ff @(posedge clk_i) begin
    if (rst_i || interrogate_done_i) begin
      busy_q <= 1'b0;
    end else if (interrogate_start_o) begin
      busy_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence force_acc;
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_adr_i[7:2] == 6'h03;
  endsequence
  sequence force_wr;
    force_acc ##0 (wb_we_i && wb_sel_i[1]);
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
  force_rd_zero_a: assert property (force_acc ##0 !wb_we_i |-> wb_dat_o == 32'h0)
    else $error("force reads nonzero");
  volt_off_a: assert property (force_wr ##0 (|wb_dat_i[13:10] && !interrogate_done_i)
    |=> !power_ctrl_enable_o) else $error("power control kept");
  retest_go_a: assert property (force_wr ##0 (wb_dat_i[14] && !busy_q)
    |=> interrogate_start_o) else $error("no retest start");
  start_cause_a: assert property ($rose(interrogate_start_o) |->
    $past(wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h03 && wb_sel_i[1] && wb_dat_i[14]))
    else $error("start without retest");
  done_power_a: assert property (interrogate_done_i && busy_q |=> power_ctrl_enable_o)
    else $error("power control not restored");
  reset_out_a: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !irq_o && !interrogate_start_o && power_ctrl_enable_o)
    else $error("bad reset outputs");
endmodule // sfe_force_event_checker

bind sfe_force_event sfe_force_event_checker chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .interrogate_done_i,
  .interrogate_start_o, .power_ctrl_enable_o, .irq_o);

// [bench/sfe_force_event_tb.sv]
// register level testbench of the socket force event block
`timescale 1ns/100ps
module sfe_force_event_tb;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, interrogate_start_o, power_ctrl_enable_o, irq_o;
  logic detect_one_live_i = 1'b1, detect_two_live_i = 1'b1, status_change_live_i = 1'b0;
  logic socket_powered_status_i = 1'b0, ready_irq_live_i = 1'b0, interrogate_done_i = 1'b0;
  logic [3:0] card_volt_caps_i = 4'ha;
  logic cardbus_detected_i = 1'b1, sixteen_bit_detected_i = 1'b0;
  logic unrecognized_card_i = 1'b1, zoom_video_capable_i = 1'b1;
  int n_fail = 0, compares = 0;
  always #2 clk_i = ~clk_i;
  sfe_force_event dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .detect_one_live_i, .detect_two_live_i,
    .status_change_live_i, .socket_powered_status_i, .ready_irq_live_i,
    .interrogate_done_i, .card_volt_caps_i, .cardbus_detected_i, .sixteen_bit_detected_i,
    .unrecognized_card_i, .zoom_video_capable_i, .interrogate_start_o,
    .power_ctrl_enable_o, .irq_o);
  task automatic test_done();
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) n_fail++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    int n;
    idle(2);
    rst_i <= 1'b0;
    idle(4);
    wr(8'h00, 32'hf, 4'hf);
    chk(power_ctrl_enable_o, 32'h1);
    rd(8'h08, 32'h3000_0006);
    rd(8'h10, 32'h2);
    rd(8'h0c, 32'h0);
    wr(8'h0c, 32'hffff_bfff, 4'hf);
    idle(1);
    chk(power_ctrl_enable_o, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h3800_3fb6);
    rd(8'h00, 32'hf);
    wr(8'h0c, 32'h0, 4'hf);
    rd(8'h08, 32'h3000_0006);
    rd(8'h00, 32'h0);
    wr(8'h0c, 32'h0000_4000, 4'h2);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (interrogate_start_o !== 1'b1 && n < 8);
    chk(interrogate_start_o, 32'h1);
    rd(8'h10, 32'h1);
    @(posedge clk_i) interrogate_done_i <= 1'b1;
    @(posedge clk_i) interrogate_done_i <= 1'b0;
    idle(1);
    rd(8'h08, 32'h3800_28a6);
    rd(8'h10, 32'h2);
    wr(8'h0c, 32'h0, 4'he);
    rd(8'h08, 32'h3000_00a6);
    wr(8'h20, 32'hffff_ffff, 4'hf);
    rd(8'h20, 32'h0);
    wr(8'h04, 32'h0, 4'hf);
    @(posedge clk_i) detect_one_live_i <= 1'b0;
    idle(4);
    chk(irq_o, 32'h0);
    rd(8'h00, 32'h2);
    rd(8'h08, 32'h3000_00a4);
    wr(8'h04, 32'h2, 4'hf);
    idle(2);
    chk(irq_o, 32'h1);
    wr(8'h00, 32'h2, 4'hf);
    idle(2);
    chk(irq_o, 32'h0);
    rd(8'h00, 32'h0);
    // live status, power and ready pins go high
    @(posedge clk_i);
    {status_change_live_i, socket_powered_status_i, ready_irq_live_i} <= 3'b111;
    idle(4);
    chk(irq_o, 32'h0);
    rd(8'h08, 32'h3000_00ed);
    rd(8'h00, 32'h9);
    wr(8'h0c, 32'h0, 4'h1);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h3000_004d);
    wr(8'h0c, 32'h0000_000e, 4'h1);
    rd(8'h00, 32'he);
    chk(irq_o, 32'h1);
    rd(8'h08, 32'h3000_004d);
    wr(8'h0c, 32'h0000_0400, 4'h2);
    idle(1);
    chk(power_ctrl_enable_o, 32'h0);
    rd(8'h08, 32'h3000_044d);
    // reset in mid-run; detect, status and power pins that differ from reset samples raise events
    @(posedge clk_i) rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    idle(4);
    chk(power_ctrl_enable_o, 32'h1);
    chk(irq_o, 32'h0);
    rd(8'h00, 32'hb);
    rd(8'h08, 32'h3000_004d);
    rd(8'h10, 32'h2);
    test_done();
  end
  initial begin
    #20000;
    n_fail++;
    test_done();
  end
endmodule // sfe_force_event_tb
